// file: common/cpm_params.svh
/*
 * Offsets, reset values and counts of the control pin mux.
 * Assumes a 10 MHz core clock and word-indexed register offsets.
 */
`ifndef CPM_PARAMS_SVH
`define CPM_PARAMS_SVH

`define CPM_CLK_HZ        10000000
`define CPM_LED_MIN_NS    100000
`define CPM_LED_CYC       ((`CPM_LED_MIN_NS * (`CPM_CLK_HZ / 1000000) + 999) / 1000)

`define CPM_ADDR_W        4
`define CPM_OFF_PINSEL    4'h0
`define CPM_OFF_MODE      4'h1
`define CPM_OFF_DIV       4'h2
`define CPM_OFF_GPIO      4'h3
`define CPM_OFF_PDIR      4'h4
`define CPM_OFF_PDATA     4'h5
`define CPM_OFF_STATUS    4'h6
`define CPM_OFF_UID       4'h7

`define CPM_SEL_W         4
`define CPM_PINSEL_RST    20'h51032
`define CPM_DIV_RST       14'h0010
`define CPM_DIV_W         14
`define CPM_UID_RST       32'h5a5a_0001 // Arbitrary identifier value

`endif

// file: common/cpm_pkg.sv
/*
 * Types of the control pin mux.
 * Assumes cpm_params.svh for the numeric constants.
 */
package cpm_pkg;

	typedef enum logic [3:0] {
		CPM_F_RS485_TX_ENABLE,
		CPM_F_POWER_ENABLE_N,
		CPM_F_TX_ACTIVITY_LED_N,
		CPM_F_RX_ACTIVITY_LED_N,
		CPM_F_ANY_ACTIVITY_LED_N,
		CPM_F_SUSPEND_N,
		CPM_F_CLOCK_OUT_FAST,
		CPM_F_CLOCK_OUT_HALF,
		CPM_F_CLOCK_OUT_QUARTER,
		CPM_F_CLOCK_OUT_EIGHTH,
		CPM_F_CTRL_PIN_GPIO,
		CPM_F_PORT_WRITE_STROBE_N,
		CPM_F_PORT_READ_STROBE_N
	} cpm_func_t;

	typedef enum logic [1:0] {
		CPM_M_UART,
		CPM_M_ASYNC,
		CPM_M_SYNC
	} cpm_mode_t;

endpackage : cpm_pkg

// file: hw/cpm_ctrl_pin_mux.sv
/*
 * Control pin function mux with byte-wide bit-bang port and fixed identifier.
 * Assumes the USB engine and UART sit on clk_in; pins reach this block raw.
 */
// Chosen here: the register offsets and the address-and-strobe port.
// Behaviour
// - Five control pins, each driving one function chosen by stored selects.
// - RS485 enable pin is active while the UART transmitter sends.
// - Power enable goes low once configured, high again in suspend.
// - Transmit LED pin pulses low during USB transmit.
// - Receive LED pin pulses low during USB receive.
// - Combined LED pin pulses low on transmit or receive.
// - Suspend pin is low during suspend, high otherwise.
// - Any pin may output one of four divided clocks.
// - Clock outputs stop in suspend and resume afterwards.
// - GPIO mode only on pins zero to three.
// - GPIO pins keep working during normal UART traffic.
// - Port strobes only on pins zero to three, in both bit-bang modes.
// - Async bit-bang turns the eight UART lines into a byte port.
// - Async bytes are applied in order, paced by an internal timer.
// - Write strobe pulses per applied byte; read strobe per async port read, per applied byte in sync.
// - Sync mode samples the port only when a written byte is applied on the timer tick.
// - Identifier is fixed; writes cannot change it.
// - Identifier readable only by register request, never on pins.
// - Fifth pin is output only, never an input function.
// - Defaults: tx LED, rx LED, RS485 enable, power enable, suspend.
`timescale 1ns/1ps
`include "cpm_params.svh"

module cpm_ctrl_pin_mux
	import cpm_pkg::*;
#(
	parameter int          LED_CYC = `CPM_LED_CYC,
	parameter logic [31:0] UID     = `CPM_UID_RST
) (
	input  wire logic                   clk_in,
	input  wire logic                   rst_in,
	input  wire logic [`CPM_ADDR_W-1:0] reg_addr_in,
	input  wire logic [31:0]            reg_wdata_in,
	input  wire logic                   reg_wr_in,
	input  wire logic                   reg_rd_in,
	output logic      [31:0]            reg_rdata_out,
	input  wire logic                   usb_configured_in,
	input  wire logic                   usb_suspend_in,
	input  wire logic                   usb_tx_active_in,
	input  wire logic                   usb_rx_active_in,
	input  wire logic                   uart_tx_busy_in,
	input  wire logic [7:0]             uart_ser_out_in,
	input  wire logic [7:0]             uart_ser_oe_in,
	output logic      [7:0]             uart_line_out,
	output logic      [7:0]             uart_line_oe_out,
	input  wire logic [7:0]             uart_line_in,
	output logic      [7:0]             uart_line_rx_out,
	output logic      [4:0]             ctrl_pin_out,
	output logic      [4:0]             ctrl_pin_oe_out,
	input  wire logic [3:0]             ctrl_pin_in
);

	logic [19:0]            pinsel_r;
	cpm_mode_t              mode_r;
	logic [`CPM_DIV_W-1:0]  div_r;
	logic [`CPM_DIV_W-1:0]  tmr_r;
	logic [3:0]             gpo_r;
	logic [3:0]             gpoe_r;
	logic [7:0]             pdir_r;
	logic [7:0]             pend_r;
	logic                   pend_v_r;
	logic [7:0]             pout_r;
	logic [7:0]             psamp_r;
	logic                   wr_n_r;
	logic                   rd_n_r;
	logic                   pwr_n_r;
	logic [3:0]             ckdiv_r;
	logic [7:0]             line_m_r;
	logic [7:0]             line_s_r;
	logic [3:0]             cpin_m_r;
	logic [3:0]             cpin_s_r;
	logic [2:0]             led_on;
	logic [31:0]            rdata_r;
	logic [4:0]             pin_r;

	// Decode
	wire bb_on    = (mode_r != CPM_M_UART);
	wire wr_sel   = reg_wr_in && (reg_addr_in == `CPM_OFF_PINSEL);
	wire wr_mode  = reg_wr_in && (reg_addr_in == `CPM_OFF_MODE);
	wire wr_div   = reg_wr_in && (reg_addr_in == `CPM_OFF_DIV);
	wire wr_gpio  = reg_wr_in && (reg_addr_in == `CPM_OFF_GPIO);
	wire wr_pdir  = reg_wr_in && (reg_addr_in == `CPM_OFF_PDIR);
	wire wr_pdata = reg_wr_in && (reg_addr_in == `CPM_OFF_PDATA) && bb_on;
	wire rd_pdata = reg_rd_in && (reg_addr_in == `CPM_OFF_PDATA) && bb_on;
	wire tick     = (tmr_r == '0);
	wire apply    = tick && pend_v_r;
	wire take     = wr_pdata && (!pend_v_r || apply);

	// Two-flop synchronisers for pin inputs
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			line_m_r <= 8'h00;
			line_s_r <= 8'h00;
			cpin_m_r <= 4'h0;
			cpin_s_r <= 4'h0;
		end else begin
			line_m_r <= uart_line_in;
			line_s_r <= line_m_r;
			cpin_m_r <= ctrl_pin_in;
			cpin_s_r <= cpin_m_r;
		end
	end

	// Configuration registers
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pinsel_r <= `CPM_PINSEL_RST;
			mode_r   <= CPM_M_UART;
			div_r    <= `CPM_DIV_RST;
			gpo_r    <= 4'h0;
			gpoe_r   <= 4'h0;
			pdir_r   <= 8'h00;
		end else begin
			if (wr_sel)
				pinsel_r <= reg_wdata_in[19:0];
			if (wr_mode)
				mode_r <= (reg_wdata_in[1:0] == 2'h3) ? CPM_M_UART
					: cpm_mode_t'(reg_wdata_in[1:0]);
			if (wr_div)
				div_r <= reg_wdata_in[`CPM_DIV_W-1:0];
			if (wr_gpio) begin
				gpo_r  <= reg_wdata_in[3:0];
				gpoe_r <= reg_wdata_in[7:4];
			end
			if (wr_pdir)
				pdir_r <= reg_wdata_in[7:0];
		end
	end

	// Byte holding register, pacing timer and strobes
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			tmr_r    <= '0;
			pend_r   <= 8'h00;
			pend_v_r <= 1'b0;
			pout_r   <= 8'h00;
			psamp_r  <= 8'h00;
			wr_n_r   <= 1'b1;
			rd_n_r   <= 1'b1;
		end else begin
			tmr_r    <= tick ? div_r : tmr_r - 1'b1;
			pend_v_r <= take || (pend_v_r && !apply);
			if (take)
				pend_r <= reg_wdata_in[7:0];
			if (apply)
				pout_r <= pend_r;
			if (apply && mode_r == CPM_M_SYNC)
				psamp_r <= line_s_r;
			wr_n_r <= !(apply && bb_on);
			rd_n_r <= !(bb_on && ((mode_r == CPM_M_SYNC) ? apply : rd_pdata));
		end
	end

	// Power enable and clock dividers
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pwr_n_r <= 1'b1;
			ckdiv_r <= 4'h0;
		end else begin
			if (usb_suspend_in)
				pwr_n_r <= 1'b1;
			else if (usb_configured_in)
				pwr_n_r <= 1'b0;
			ckdiv_r <= usb_suspend_in ? 4'h0 : ckdiv_r + 1'b1;
		end
	end

	// Activity pulse stretchers: transmit, receive, either
	wire [2:0] act = {usb_tx_active_in | usb_rx_active_in,
		usb_rx_active_in, usb_tx_active_in};
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_led
			logic [15:0] cnt_r;
			always_ff @(posedge clk_in or posedge rst_in) begin
				if (rst_in)
					cnt_r <= '0;
				else if (act[g])
					cnt_r <= 16'(LED_CYC);
				else if (cnt_r != '0)
					cnt_r <= cnt_r - 1'b1;
			end
			assign led_on[g] = act[g] || (cnt_r != '0);
		end
	endgenerate

	// Per-pin function select
	generate
		for (g = 0; g < 5; g++) begin : g_pin
			cpm_func_t f;
			logic      v;
			wire       low4 = (g < 4);
			assign f = cpm_func_t'(pinsel_r[g*4 +: 4]);
			always_comb begin
				case (f)
					CPM_F_RS485_TX_ENABLE:    v = uart_tx_busy_in;
					CPM_F_POWER_ENABLE_N:     v = pwr_n_r;
					CPM_F_TX_ACTIVITY_LED_N:  v = !led_on[0];
					CPM_F_RX_ACTIVITY_LED_N:  v = !led_on[1];
					CPM_F_ANY_ACTIVITY_LED_N: v = !led_on[2];
					CPM_F_SUSPEND_N:          v = !usb_suspend_in;
					CPM_F_CLOCK_OUT_FAST:     v = ckdiv_r[0];
					CPM_F_CLOCK_OUT_HALF:     v = ckdiv_r[1];
					CPM_F_CLOCK_OUT_QUARTER:  v = ckdiv_r[2];
					CPM_F_CLOCK_OUT_EIGHTH:   v = ckdiv_r[3];
					CPM_F_CTRL_PIN_GPIO:      v = low4 ? gpo_r[g % 4] : 1'b1;
					CPM_F_PORT_WRITE_STROBE_N: v = low4 ? wr_n_r : 1'b1;
					CPM_F_PORT_READ_STROBE_N:  v = low4 ? rd_n_r : 1'b1;
					default:                  v = 1'b1;
				endcase
			end
			always_ff @(posedge clk_in or posedge rst_in) begin
				if (rst_in)
					pin_r[g] <= 1'b1;
				else
					pin_r[g] <= v;
			end
			assign ctrl_pin_oe_out[g] = !(low4 && f == CPM_F_CTRL_PIN_GPIO
				&& !gpoe_r[g % 4]);
		end
	endgenerate
	assign ctrl_pin_out = pin_r;

	// UART line steering
	assign uart_line_out    = bb_on ? pout_r : uart_ser_out_in;
	assign uart_line_oe_out = bb_on ? pdir_r : uart_ser_oe_in;
	assign uart_line_rx_out = bb_on ? 8'hff : line_s_r;

	// Read data, one cycle after the strobe
	wire [7:0] pread = (mode_r == CPM_M_SYNC) ? psamp_r : line_s_r;
	always_comb begin
		case (reg_addr_in)
			`CPM_OFF_PINSEL: rdata_r = {12'h000, pinsel_r};
			`CPM_OFF_MODE:   rdata_r = {30'h0, mode_r};
			`CPM_OFF_DIV:    rdata_r = {18'h0, div_r};
			`CPM_OFF_GPIO:   rdata_r = {20'h0, cpin_s_r, gpoe_r, gpo_r};
			`CPM_OFF_PDIR:   rdata_r = {24'h0, pdir_r};
			`CPM_OFF_PDATA:  rdata_r = {24'h0, pread};
			`CPM_OFF_STATUS: rdata_r = {28'h0, pend_v_r, pwr_n_r,
				usb_suspend_in, usb_configured_in};
			`CPM_OFF_UID:    rdata_r = UID;
			default:         rdata_r = 32'h0;
		endcase
	end
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in)
			reg_rdata_out <= 32'h0;
		else
			reg_rdata_out <= reg_rd_in ? rdata_r : 32'h0;
	end

	// Cycles a queued byte has waited for the timer
	logic [`CPM_DIV_W:0]    wait_r;
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in)
			wait_r <= '0;
		else if (!pend_v_r || apply)
			wait_r <= '0;
		else
			wait_r <= wait_r + 1'b1;
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	sequence s_cfg;
		usb_configured_in && !usb_suspend_in;
	endsequence
	sequence s_pwr_low;
		!pwr_n_r;
	endsequence
	sequence s_apply_bb;
		apply && bb_on;
	endsequence
	sequence s_port_out;
		pout_r == $past(pend_r) && !wr_n_r;
	endsequence
	sequence s_wr_pin;
		pinsel_r[3:0] == 4'hb;
	endsequence

	pwr_on_a: assert property (s_cfg |=> s_pwr_low)
		else $error("power enable not low after configure");
	pwr_off_a: assert property (usb_suspend_in |=> pwr_n_r)
		else $error("power enable not high in suspend");
	clk_stop_a: assert property (usb_suspend_in[*2] |-> ckdiv_r == 4'h0)
		else $error("clock output toggles in suspend");
	led_hold_a: assert property ($fell(usb_tx_active_in) |-> led_on[0][*3])
		else $error("led pulse too short");
	pin4_out_a: assert property (ctrl_pin_oe_out[4])
		else $error("fifth pin not driven");
	apply_a: assert property (s_apply_bb |=> s_port_out)
		else $error("byte not applied with write strobe");
	order_a: assert property (pend_v_r |-> !wait_r[`CPM_DIV_W])
		else $error("queued byte never applied");
	sync_a: assert property (mode_r == CPM_M_SYNC && !apply |=> $stable(psamp_r))
		else $error("sync sample changed without a write");
	bb_line_a: assert property (bb_on |-> uart_line_out == pout_r)
		else $error("port not on uart lines");
	uid_a: assert property (reg_rd_in && reg_addr_in == `CPM_OFF_UID
		|=> reg_rdata_out == UID)
		else $error("identifier changed");
	rs485_a: assert property (pinsel_r[11:8] == 4'h0 |=> pin_r[2] == $past(uart_tx_busy_in))
		else $error("rs485 enable wrong");
	sleep_a: assert property (pinsel_r[19:16] == 4'h5 |=> pin_r[4] == !$past(usb_suspend_in))
		else $error("suspend pin wrong");

	// Byte port strobes and holding register
	wr_pin_a: assert property (s_apply_bb ##1 s_wr_pin |=> !pin_r[0])
		else $error("write strobe pin not low after apply");

	wr_only_a: assert property (!(apply && bb_on) |=> wr_n_r)
		else $error("write strobe without apply");

	rd_async_a: assert property (mode_r == CPM_M_ASYNC && reg_rd_in
		&& reg_addr_in == `CPM_OFF_PDATA |=> !rd_n_r)
		else $error("read strobe missing on port read");

	rd_sync_a: assert property (mode_r == CPM_M_SYNC && apply |=> !rd_n_r)
		else $error("read strobe missing on sync apply");

	take_a: assert property (take |=> pend_v_r && pend_r == $past(reg_wdata_in[7:0]))
		else $error("port byte not held");

	rx_idle_a: assert property (bb_on |-> uart_line_rx_out == 8'hff)
		else $error("uart receive not idle in bit-bang");

	// Activity LEDs
	led_rx_a: assert property ($fell(usb_rx_active_in) |-> led_on[1][*3])
		else $error("receive led pulse too short");

	led_any_a: assert property (usb_tx_active_in || usb_rx_active_in |-> led_on[2])
		else $error("combined led not lit");

	tx_led_a: assert property (pinsel_r[3:0] == 4'h2 |=> pin_r[0] == !$past(led_on[0]))
		else $error("transmit led pin wrong");

	rx_led_a: assert property (pinsel_r[3:0] == 4'h3 |=> pin_r[0] == !$past(led_on[1]))
		else $error("receive led pin wrong");

	any_led_a: assert property (pinsel_r[3:0] == 4'h4 |=> pin_r[0] == !$past(led_on[2]))
		else $error("combined led pin wrong");

	// Pin function outputs
	pin_gpio_a: assert property (pinsel_r[3:0] == 4'ha |=> pin_r[0] == $past(gpo_r[0]))
		else $error("gpio pin level wrong");

	gpio_oe_a: assert property (pinsel_r[3:0] == 4'ha |-> ctrl_pin_oe_out[0] == gpoe_r[0])
		else $error("gpio pin enable wrong");

	strobe_pin_a: assert property (pinsel_r[3:0] == 4'hb |=> pin_r[0] == $past(wr_n_r))
		else $error("write strobe pin wrong");

	clk_pin_a: assert property (pinsel_r[3:0] == 4'h6 |=> pin_r[0] == $past(ckdiv_r[0]))
		else $error("fast clock pin wrong");

	clk_half_a: assert property (pinsel_r[7:4] == 4'h7 |=> pin_r[1] == $past(ckdiv_r[1]))
		else $error("half clock pin wrong");

	pwr_pin_a: assert property (pinsel_r[15:12] == 4'h1 |=> pin_r[3] == $past(pwr_n_r))
		else $error("power enable pin wrong");

	pin4_func_a: assert property (pinsel_r[19:16] >= 4'ha |=> pin_r[4])
		else $error("fifth pin given an input function");

	// Register read port
	rdata_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
		else $error("read data without a read");

endmodule : cpm_ctrl_pin_mux

// file: verification/cpm_ext_model.sv
/*
 * External board logic on the eight port lines and the control pins.
 * Assumes the design's drive wins wherever its enable is high.
 */
`timescale 1ns/1ps
module cpm_ext_model (
	input  wire logic [7:0] line_out_in,
	input  wire logic [7:0] line_oe_in,
	input  wire logic [4:0] pin_out_in,
	input  wire logic [4:0] pin_oe_in,
	input  wire logic [7:0] ext_val_in,
	output logic      [7:0] line_in_out,
	output logic      [3:0] pin_in_out,
	output logic      [7:0] cap_out
);
	// Released lines take the board's own value
	assign line_in_out = (line_out_in & line_oe_in) | (ext_val_in & ~line_oe_in);
	assign pin_in_out  = (pin_out_in[3:0] & pin_oe_in[3:0]) | (ext_val_in[3:0] & ~pin_oe_in[3:0]);
	// Write strobe end on pin 0 clocks the port byte in
	always_ff @(posedge pin_out_in[0]) begin
		cap_out <= line_out_in;
	end
endmodule : cpm_ext_model

// file: verification/ctrl_pin_function_mux_bitbang_tb_top.sv
/*
 * Self-checking bench of the control pin mux.
 * Assumes cpm_params.svh offsets and a short LED stretch.
 */
`timescale 1ns/1ps
`include "cpm_params.svh"
module ctrl_pin_function_mux_bitbang_tb_top;
	localparam int LC = 4;
	logic        clk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic [3:0]  reg_addr_in = 4'h0;
	logic [31:0] reg_wdata_in = 32'h0;
	logic        reg_wr_in = 1'b0;
	logic        reg_rd_in = 1'b0;
	logic [31:0] reg_rdata_out;
	logic        cfg = 1'b0, susp = 1'b0, utx = 1'b0, urx = 1'b0, busy = 1'b0;
	logic [7:0]  ser = 8'h0, ext = 8'h0, line_out, line_oe, line_in, line_rx, cap, g, b, e1;
	logic [4:0]  pin_out, pin_oe, p;
	logic [3:0]  pin_in;
	logic [31:0] d;
	int          fails = 0, n_compared = 0, cnt, ex;
	int          tg[5];

	always #50 clk_in = ~clk_in;

	cpm_ctrl_pin_mux #(.LED_CYC(LC)) u_dut (
		.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .usb_configured_in(cfg), .usb_suspend_in(susp),
		.usb_tx_active_in(utx), .usb_rx_active_in(urx), .uart_tx_busy_in(busy),
		.uart_ser_out_in(ser), .uart_ser_oe_in(8'hff), .uart_line_out(line_out),
		.uart_line_oe_out(line_oe), .uart_line_in(line_in), .uart_line_rx_out(line_rx),
		.ctrl_pin_out(pin_out), .ctrl_pin_oe_out(pin_oe), .ctrl_pin_in(pin_in)
	);

	cpm_ext_model u_ext (
		.line_out_in(line_out), .line_oe_in(line_oe), .pin_out_in(pin_out),
		.pin_oe_in(pin_oe), .ext_val_in(ext), .line_in_out(line_in),
		.pin_in_out(pin_in), .cap_out(cap)
	);

	task automatic finish_test();
		if (fails == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : finish_test

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		n_compared++;
		if (s !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : cyc

	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		reg_addr_in <= a;
		reg_wdata_in <= v;
		reg_wr_in <= 1'b1;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		#1 v = reg_rdata_out;
	endtask : rd

	// Pin level read back through the sync flops
	function automatic logic [3:0] gexp(input logic [7:0] gv, input logic [7:0] ev);
		return (gv[3:0] & gv[7:4]) | (ev[3:0] & ~gv[7:4]);
	endfunction : gexp

	initial begin
		repeat (5000) @(posedge clk_in);
		fails++;
		finish_test();
	end

	initial begin
		void'($urandom(23422));
		repeat (3) @(posedge clk_in);
		rst_in <= 1'b0;
		cyc(1);
		chk("pin_oe", 5'h1f, pin_oe);
		rd(`CPM_OFF_PINSEL, d);
		chk("pinsel", {12'h0, 4'h5, 4'h1, 4'h0, 4'h3, 4'h2}, d);
		rd(`CPM_OFF_UID, d);
		chk("uid", `CPM_UID_RST, d);
		wr(`CPM_OFF_UID, 32'h0);
		rd(`CPM_OFF_UID, d);
		chk("uid_wr", `CPM_UID_RST, d);
		rd(4'h8, d);
		chk("unmapped", 32'h0, d);
		wr(`CPM_OFF_PINSEL, 32'h51032);
		cfg <= 1'b1;
		busy <= 1'b1;
		cyc(3);
		chk("pwr_cfg", 5'h14, pin_out & 5'h1c);
		susp <= 1'b1;
		busy <= 1'b0;
		cyc(3);
		chk("pwr_susp", 5'h08, pin_out & 5'h1c);
		susp <= 1'b0;
		cyc(3);
		chk("pwr_back", 5'h10, pin_out & 5'h1c);
		for (int k = 0; k < 3; k++) begin
			wr(`CPM_OFF_PINSEL, 32'h51030 | (k + 2));
			utx <= (k != 1);
			urx <= (k == 1);
			@(posedge clk_in);
			utx <= 1'b0;
			urx <= 1'b0;
			cnt = 0;
			repeat (16) begin
				@(posedge clk_in);
				#1 cnt += int'(pin_out[0] === 1'b0);
			end
			chk("led_len", 1, cnt >= LC && cnt <= LC + 2);
		end
		wr(`CPM_OFF_PINSEL, 32'h69876);
		for (int s = 0; s < 2; s++) begin
			susp <= s[0];
			cyc(4);
			p = pin_out;
			tg = '{0, 0, 0, 0, 0};
			repeat (32) begin
				cyc(1);
				for (int i = 0; i < 5; i++) tg[i] += int'(pin_out[i] !== p[i]);
				p = pin_out;
			end
			for (int i = 0; i < 5; i++) begin
				ex = s ? 0 : 32 >> (i % 4);
				chk("clk_tog", 1, tg[i] >= ex - s - 1 + s && tg[i] <= ex + 1 - s);
			end
		end
		susp <= 1'b0;
		wr(`CPM_OFF_PINSEL, 32'haaaaa);
		repeat (4) begin
			g = 8'($urandom);
			ext <= 8'($urandom);
			ser <= 8'($urandom);
			busy <= 1'b1;
			wr(`CPM_OFF_GPIO, {24'h0, g});
			cyc(4);
			chk("gpio_oe", {1'b1, g[7:4]}, pin_oe);
			chk("gpio_out", {1'b1, g[3:0] & g[7:4]}, pin_out & {1'b1, g[7:4]});
			chk("uart_line", ser, line_out);
			chk("uart_rx", ser, line_rx);
			rd(`CPM_OFF_GPIO, d);
			chk("gpio_in", gexp(g, ext), d[11:8]);
		end
		busy <= 1'b0;
		wr(`CPM_OFF_PINSEL, 32'h510cb);
		wr(`CPM_OFF_DIV, 32'h3);
		wr(`CPM_OFF_PDIR, 32'hff);
		wr(`CPM_OFF_MODE, 32'h1);
		for (int k = 0; k < 4; k++) begin
			b = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
			wr(`CPM_OFF_PDATA, {24'h0, b});
			cyc(12);
			chk("port", b, line_out);
			chk("port_cap", b, cap);
			chk("port_oe", 8'hff, line_oe);
			chk("rx_idle", 8'hff, line_rx);
			rd(`CPM_OFF_PDATA, d);
			chk("port_rd", b, d[7:0]);
			cyc(1);
			chk("rd_strobe", 1'b0, pin_out[1]);
		end
		wr(`CPM_OFF_MODE, 32'h2);
		wr(`CPM_OFF_PDIR, 32'h0f);
		b = 8'($urandom);
		e1 = 8'($urandom);
		ext <= e1;
		cyc(4);
		wr(`CPM_OFF_PDATA, {24'h0, b});
		cyc(12);
		ext <= ~e1;
		cyc(4);
		rd(`CPM_OFF_PDATA, d);
		chk("sync_smp", e1 & 8'hf0, d[7:0] & 8'hf0);
		chk("sync_out", b[3:0], line_out[3:0]);
		wr(`CPM_OFF_MODE, 32'h3);
		chk("uart_back", ser, line_out);
		rd(`CPM_OFF_MODE, d);
		chk("mode3", 32'h0, d);
		finish_test();
	end
endmodule : ctrl_pin_function_mux_bitbang_tb_top
